// [logic/cod_decode_timing.sv]
/*
  Opcode decode and cycle timing for branches, bit test and branch,
  read-modify-write, multiply and flag-control instructions. Holds
  the accumulator, index register and condition codes, reachable
  over a small register port.
  Assumes the core hands over the opcode, up to two following bytes,
  the opcode address and the memory operand already fetched.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
// Notes on behaviour
// - 20-2F are 2-byte relative branches, 3 cycles; 20 always, 21 never
// - 22 unsigned higher, 23 lower-or-same, 24 carry clear, 25 carry set
// - 26 not equal, 27 equal, 28 half-carry clear, 29 half-carry set
// - 2A plus, 2B minus, 2C mask clear, 2D mask set
// - 2E branches on interrupt line low, 2F on line high
// - opcode 2n tests bit n set, 3 bytes, 5 cycles
// - opcode 01+2n tests bit n clear, 3 bytes, 5 cycles
// - high nibble picks operand and length/cycles for read-modify-write
// - low nibble picks the read-modify-write function
// - memory test takes one cycle fewer than the other rmw functions of the same memory form
// - 98-9B clear/set carry and mask, 1 byte, 2 cycles
// - multiply puts high byte in index, low in acc; clears H, C; 11 cycles
`timescale 1ns/1ps
module cod_decode_timing
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // instruction request
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] pcIn,
  input  wire logic [7:0]  memData,
  input  wire logic        irqLine,
  // instruction answer
  output logic             busy,
  output logic             done,
  output logic             taken,
  output logic             illegal,
  output logic [15:0]      nextPc,
  output logic             memWe,
  output logic [7:0]       memWdata,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata
);

  cod_pkg::cod_regs_type r_r;
  cod_pkg::cod_regs_type r_nxt;

  logic       take;
  logic [3:0] hiNib;
  logic [3:0] loNib;
  logic [7:0] rmwOperand;
  logic [7:0] aluResult;
  logic       aluCarry;
  logic       aluCarryUpd;
  logic       aluNeg;
  logic       aluZero;
  logic       aluWrites;
  logic       aluLegal;

  assign take  = start && (r_r.state == cod_pkg::ST_IDLE);
  assign hiNib = opcode[7:4];
  assign loNib = opcode[3:0];

  // ---------------------------------------------------------------
  // operand select and function unit
  // ---------------------------------------------------------------
  // operand by nibble
  always_comb
  begin
    case (hiNib)
      cod_pkg::HI_ACC: rmwOperand = r_r.acc;
      cod_pkg::HI_IDX: rmwOperand = r_r.idx;
      default:         rmwOperand = memData;
    endcase
  end

  cod_rmw_alu uAlu
  (
    .func     (loNib),
    .operand  (rmwOperand),
    .carryIn  (r_r.ccr[cod_pkg::CCR_C]),
    .result   (aluResult),
    .carryOut (aluCarry),
    .carryUpd (aluCarryUpd),
    .negOut   (aluNeg),
    .zeroOut  (aluZero),
    .writes   (aluWrites),
    .legal    (aluLegal)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // everything is decided at take; done marks the last cycle
  always_comb
  begin
    logic        cond;
    logic [3:0]  cyc;
    logic [1:0]  len;
    logic [15:0] seqPc;
    logic [15:0] prod;
    logic        isTst;
    cond  = 1'b0;
    cyc   = cod_pkg::CYC_BAD;
    len   = cod_pkg::LEN_1;
    seqPc = 16'h0000;
    prod  = {8'h00, r_r.idx} * {8'h00, r_r.acc};
    isTst = (loNib == cod_pkg::FN_TST);
    r_nxt = r_r;
    r_nxt.done   = 1'b0;
    r_nxt.memWe  = 1'b0;
    r_nxt.rdData = 8'h00;

    // software writes; a take in the same cycle overrides below
    if (regWr)
    begin
      case (regAddr)
        cod_pkg::REG_ACC: r_nxt.acc = regWdata;
        cod_pkg::REG_IDX: r_nxt.idx = regWdata;
        cod_pkg::REG_CCR: r_nxt.ccr = regWdata[4:0];
        default:          r_nxt.ccr = r_r.ccr;
      endcase
    end

    // read data stand for the one cycle after the strobe
    if (regRd)
    begin
      case (regAddr)
        cod_pkg::REG_ACC:  r_nxt.rdData = r_r.acc;
        cod_pkg::REG_IDX:  r_nxt.rdData = r_r.idx;
        cod_pkg::REG_CCR:  r_nxt.rdData = {3'h0, r_r.ccr};
        cod_pkg::REG_STAT: r_nxt.rdData = {5'h00, r_r.illegal, r_r.taken,
                                           r_r.busy};
        cod_pkg::REG_PCL:  r_nxt.rdData = r_r.nextPc[7:0];
        cod_pkg::REG_PCH:  r_nxt.rdData = r_r.nextPc[15:8];
        default:           r_nxt.rdData = 8'h00;
      endcase
    end

    case (r_r.state)
      cod_pkg::ST_IDLE:
      begin
        if (take)
        begin
          r_nxt.illegal = 1'b0;
          r_nxt.taken   = 1'b0;
          r_nxt.wePend  = 1'b0;
          if (hiNib == cod_pkg::HI_REL)
          begin
            // pairs share a test, odd opcode inverts it
            case (opcode[3:1])
              3'h0: cond = 1'b1;
              // higher means neither carry nor zero
              3'h1: cond = ~(r_r.ccr[cod_pkg::CCR_C] |
                             r_r.ccr[cod_pkg::CCR_Z]);
              3'h2: cond = ~r_r.ccr[cod_pkg::CCR_C];
              3'h3: cond = ~r_r.ccr[cod_pkg::CCR_Z];
              3'h4: cond = ~r_r.ccr[cod_pkg::CCR_H];
              3'h5: cond = ~r_r.ccr[cod_pkg::CCR_N];
              3'h6: cond = ~r_r.ccr[cod_pkg::CCR_I];
              3'h7: cond = ~irqLine;
              default: cond = 1'b0;
            endcase
            r_nxt.taken = cond ^ opcode[0];
            cyc = cod_pkg::CYC_REL;
            len = cod_pkg::LEN_2;
          end
          else if (hiNib == cod_pkg::HI_BTB)
          begin
            // even opcode branches on set bit
            // odd opcode branches on clear bit
            r_nxt.taken = memData[opcode[3:1]] ^ opcode[0];
            r_nxt.ccr[cod_pkg::CCR_C] = memData[opcode[3:1]];
            cyc = cod_pkg::CYC_BTB;
            len = cod_pkg::LEN_3;
          end
          else if (opcode == cod_pkg::OP_MUL)
          begin
            // high byte to index, low byte to accumulator
            r_nxt.idx = prod[15:8];
            r_nxt.acc = prod[7:0];
            r_nxt.ccr[cod_pkg::CCR_H] = 1'b0;
            r_nxt.ccr[cod_pkg::CCR_C] = 1'b0;
            cyc = cod_pkg::CYC_MUL;
          end
          else if (hiNib >= cod_pkg::HI_DIR && hiNib <= cod_pkg::HI_IX &&
                   aluLegal)
          begin
            // length and cycles by addressing form
            // memory test is one cycle shorter
            case (hiNib)
              cod_pkg::HI_DIR:
              begin
                cyc = isTst ? cod_pkg::CYC_TST_DIR : cod_pkg::CYC_RMW_DIR;
                len = cod_pkg::LEN_2;
              end
              cod_pkg::HI_IX1:
              begin
                cyc = isTst ? cod_pkg::CYC_TST_IX1 : cod_pkg::CYC_RMW_IX1;
                len = cod_pkg::LEN_2;
              end
              cod_pkg::HI_IX:
                cyc = isTst ? cod_pkg::CYC_TST_IX : cod_pkg::CYC_RMW_IX;
              default:
                cyc = cod_pkg::CYC_RMW_REG;
            endcase
            // results go back where the operand came from
            if (aluWrites && hiNib == cod_pkg::HI_ACC)
              r_nxt.acc = aluResult;
            else if (aluWrites && hiNib == cod_pkg::HI_IDX)
              r_nxt.idx = aluResult;
            else
              r_nxt.wePend = aluWrites;
            r_nxt.memWdata = aluResult;
            r_nxt.ccr[cod_pkg::CCR_N] = aluNeg;
            r_nxt.ccr[cod_pkg::CCR_Z] = aluZero;
            if (aluCarryUpd)
              r_nxt.ccr[cod_pkg::CCR_C] = aluCarry;
          end
          else if (opcode[7:2] == cod_pkg::OP_CLC[7:2])
          begin
            // bit 1 picks mask or carry, bit 0 the value
            if (opcode[1])
              r_nxt.ccr[cod_pkg::CCR_I] = opcode[0];
            else
              r_nxt.ccr[cod_pkg::CCR_C] = opcode[0];
            cyc = cod_pkg::CYC_CTRL;
          end
          else
            r_nxt.illegal = 1'b1;

          seqPc = 16'(pcIn + {14'h0000, len});
          // signed offset from the following instruction
          // only relative (bit 5 set) and bit-test branches can be taken
          r_nxt.nextPc = seqPc;
          if (r_nxt.taken && opcode[5])
            r_nxt.nextPc = 16'(seqPc + {{8{operand1[7]}}, operand1});
          else if (r_nxt.taken)
            r_nxt.nextPc = 16'(seqPc + {{8{operand2[7]}}, operand2});
          r_nxt.cnt   = 4'(cyc - 4'h1);
          r_nxt.state = cod_pkg::ST_EXEC;
          r_nxt.busy  = 1'b1;
        end
      end
      cod_pkg::ST_EXEC:
      begin
        // count down so done lands exactly on the last cycle
        if (r_r.cnt == 4'h1)
        begin
          r_nxt.state = cod_pkg::ST_IDLE;
          r_nxt.busy  = 1'b0;
          r_nxt.done  = 1'b1;
          r_nxt.memWe = r_r.wePend;
        end
        else
          r_nxt.cnt = 4'(r_r.cnt - 4'h1);
      end
      default:
      begin
        r_nxt.state = cod_pkg::ST_IDLE;
        r_nxt.busy  = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      r_r          <= '0;
      r_r.state    <= cod_pkg::ST_IDLE;
      r_r.acc      <= cod_pkg::ACC_RST;
      r_r.idx      <= cod_pkg::IDX_RST;
      r_r.ccr      <= cod_pkg::CCR_RST;
      r_r.nextPc   <= cod_pkg::PC_RST;
    end
    else
      r_r <= r_nxt;
  end

  // outputs straight from the state register
  assign busy     = r_r.busy;
  assign done     = r_r.done;
  assign taken    = r_r.taken;
  assign illegal  = r_r.illegal;
  assign nextPc   = r_r.nextPc;
  assign memWe    = r_r.memWe;
  assign memWdata = r_r.memWdata;
  assign regRdata = r_r.rdData;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // one clock domain, so all checks share the clock and reset gating
  default clocking chkClk @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // a take may fall in the done cycle of the one before, so start at c1
  a_rel_timing: assert property (
    take && hiNib == cod_pkg::HI_REL |=> !done ##1 !done ##1 done)
    else $error("relative branch did not finish in 3 cycles");
  a_never_jump: assert property (
    take && opcode == 8'h21 |=> !taken && nextPc == 16'($past(pcIn) + 16'h2))
    else $error("never-branch was taken");
  a_higher_jump: assert property (
    take && opcode == 8'h22 |=> taken == !($past(r_r.ccr[cod_pkg::CCR_C])
                                  || $past(r_r.ccr[cod_pkg::CCR_Z])))
    else $error("higher branch decision wrong");
  a_equal_jump: assert property (
    take && opcode == 8'h27 |=> taken == $past(r_r.ccr[cod_pkg::CCR_Z]))
    else $error("equal branch decision wrong");
  a_irq_jump: assert property (
    take && opcode == 8'h2e |=> taken == !$past(irqLine))
    else $error("interrupt-line branch decision wrong");
  a_bit_test: assert property (
    take && hiNib == cod_pkg::HI_BTB |=> taken ==
      ($past(memData[opcode[3:1]]) ^ $past(opcode[0])) ##4 done)
    else $error("bit test branch wrong decision or timing");
  a_test_timing: assert property (
    take && opcode == 8'h3d |-> ##3 !done ##1 done)
    else $error("direct test not 4 cycles");
  a_ix1_timing: assert property (
    take && opcode == 8'h6c |-> ##5 !done ##1 done && memWe)
    else $error("offset indexed increment not 6 cycles");
  a_mul_result: assert property (
    take && opcode == cod_pkg::OP_MUL |=> {r_r.idx, r_r.acc} ==
      {8'h00, $past(r_r.acc)} * {8'h00, $past(r_r.idx)} &&
      !r_r.ccr[cod_pkg::CCR_C] && !r_r.ccr[cod_pkg::CCR_H] ##10 done)
    else $error("multiply result or timing wrong");
  a_flag_ctrl: assert property (
    take && opcode == cod_pkg::OP_SEI |=> r_r.ccr[cod_pkg::CCR_I] ##1 done)
    else $error("mask set wrong");

endmodule

// [logic/cod_pkg.sv]
/*
  Shared constants and types for the opcode decode and timing block:
  opcode fields, cycle counts, instruction lengths, flag positions,
  register offsets and reset values.
  Assumes a single 250 MHz clock and a synchronous active-high reset.
*/
package cod_pkg;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [3:0] HI_BTB      = 4'h0;  // bit test and branch
  localparam logic [3:0] HI_REL      = 4'h2;  // relative branches
  localparam logic [3:0] HI_DIR      = 4'h3;  // rmw direct
  localparam logic [3:0] HI_ACC      = 4'h4;  // rmw accumulator
  localparam logic [3:0] HI_IDX      = 4'h5;  // rmw index register
  localparam logic [3:0] HI_IX1      = 4'h6;  // rmw indexed, 8-bit offset
  localparam logic [3:0] HI_IX       = 4'h7;  // rmw indexed, no offset

  localparam logic [3:0] FN_NEG      = 4'h0;
  localparam logic [3:0] FN_COM      = 4'h3;
  localparam logic [3:0] FN_LSR      = 4'h4;
  localparam logic [3:0] FN_ROR      = 4'h6;
  localparam logic [3:0] FN_ASR      = 4'h7;
  localparam logic [3:0] FN_LSL      = 4'h8;
  localparam logic [3:0] FN_ROL      = 4'h9;
  localparam logic [3:0] FN_DEC      = 4'ha;
  localparam logic [3:0] FN_INC      = 4'hc;
  localparam logic [3:0] FN_TST      = 4'hd;
  localparam logic [3:0] FN_CLR      = 4'hf;

  localparam logic [7:0] OP_MUL      = 8'h42;
  localparam logic [7:0] OP_CLC      = 8'h98;
  localparam logic [7:0] OP_SEC      = 8'h99;
  localparam logic [7:0] OP_CLI      = 8'h9a;
  localparam logic [7:0] OP_SEI      = 8'h9b;

  // ---------------------------------------------------------------
  // cycle counts and lengths
  // ---------------------------------------------------------------
  localparam logic [3:0] CYC_REL     = 4'h3;
  localparam logic [3:0] CYC_BTB     = 4'h5;
  localparam logic [3:0] CYC_RMW_REG = 4'h3;
  localparam logic [3:0] CYC_RMW_DIR = 4'h5;
  localparam logic [3:0] CYC_RMW_IX  = 4'h5;
  localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
  localparam logic [3:0] CYC_TST_DIR = 4'h4;
  localparam logic [3:0] CYC_TST_IX  = 4'h4;
  localparam logic [3:0] CYC_TST_IX1 = 4'h5;
  localparam logic [3:0] CYC_MUL     = 4'hb;
  localparam logic [3:0] CYC_CTRL    = 4'h2;
  localparam logic [3:0] CYC_BAD     = 4'h2;

  localparam logic [1:0] LEN_1       = 2'h1;
  localparam logic [1:0] LEN_2       = 2'h2;
  localparam logic [1:0] LEN_3       = 2'h3;

  // ---------------------------------------------------------------
  // condition code bits, status bits, registers
  // ---------------------------------------------------------------
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_TAKEN = 1;
  localparam int STAT_BAD   = 2;

  localparam logic [3:0] REG_ACC  = 4'h0;
  localparam logic [3:0] REG_IDX  = 4'h1;
  localparam logic [3:0] REG_CCR  = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_PCL  = 4'h4;
  localparam logic [3:0] REG_PCH  = 4'h5;

  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [7:0]  IDX_RST = 8'h00;
  localparam logic [4:0]  CCR_RST = 5'h08;  // mask set out of reset
  localparam logic [15:0] PC_RST  = 16'h0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } cod_state_type;

  typedef struct packed {
    cod_state_type state;
    logic [3:0]    cnt;
    logic [7:0]    acc;
    logic [7:0]    idx;
    logic [4:0]    ccr;
    logic          busy;
    logic          done;
    logic          taken;
    logic          illegal;
    logic          wePend;
    logic          memWe;
    logic [7:0]    memWdata;
    logic [15:0]   nextPc;
    logic [7:0]    rdData;
  } cod_regs_type;

endpackage

// [logic/cod_rmw_alu.sv]
/*
  Read-modify-write function unit: works one operand byte by the low
  opcode nibble and returns the result with its flag effects.
  Purely combinational; the caller registers everything it keeps.
*/
`timescale 1ns/1ps
module cod_rmw_alu
(
  // request
  input  wire logic [3:0] func,
  input  wire logic [7:0] operand,
  input  wire logic       carryIn,
  // answer
  output logic [7:0]      result,
  output logic            carryOut,
  output logic            carryUpd,
  output logic            negOut,
  output logic            zeroOut,
  output logic            writes,
  output logic            legal
);

  // ---------------------------------------------------------------
  // function select
  // ---------------------------------------------------------------
  // unlisted nibbles are reported as not legal and write nothing
  always_comb
  begin
    result   = operand;
    carryOut = carryIn;
    carryUpd = 1'b1;
    writes   = 1'b1;
    legal    = 1'b1;
    case (func)
      cod_pkg::FN_NEG:
      begin
        result   = 8'(8'h00 - operand);
        carryOut = (operand != 8'h00);
      end
      cod_pkg::FN_COM:
      begin
        result   = ~operand;
        carryOut = 1'b1;
      end
      cod_pkg::FN_LSR:
      begin
        result   = {1'b0, operand[7:1]};
        carryOut = operand[0];
      end
      cod_pkg::FN_ROR:
      begin
        result   = {carryIn, operand[7:1]};
        carryOut = operand[0];
      end
      cod_pkg::FN_ASR:
      begin
        result   = {operand[7], operand[7:1]};
        carryOut = operand[0];
      end
      cod_pkg::FN_LSL:
      begin
        result   = {operand[6:0], 1'b0};
        carryOut = operand[7];
      end
      cod_pkg::FN_ROL:
      begin
        result   = {operand[6:0], carryIn};
        carryOut = operand[7];
      end
      cod_pkg::FN_DEC:
      begin
        result   = 8'(operand - 8'h01);
        carryUpd = 1'b0;
      end
      cod_pkg::FN_INC:
      begin
        result   = 8'(operand + 8'h01);
        carryUpd = 1'b0;
      end
      cod_pkg::FN_TST:
      begin
        carryUpd = 1'b0;
        writes   = 1'b0;  // test only looks, never stores
      end
      cod_pkg::FN_CLR:
      begin
        result   = 8'h00;
        carryUpd = 1'b0;
      end
      default:
      begin
        carryUpd = 1'b0;
        writes   = 1'b0;
        legal    = 1'b0;
      end
    endcase
    negOut  = result[7];
    zeroOut = (result == 8'h00);
  end

endmodule

// [dv/cod_decode_timing_tb_top.sv]
/*
  Self-checking bench for the opcode decode and timing block.
  Assumes the register map, flag positions and cycle counts of cod_pkg.
*/
`timescale 1ns/1ps
module cod_decode_timing_tb_top;
  // ---------------------------------------------------------------
  // stimulus and design
  // ---------------------------------------------------------------
  logic        clock    = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        start    = 1'b0;
  logic [7:0]  opcode   = 8'h00;
  logic [7:0]  operand1 = 8'h00;
  logic [7:0]  operand2 = 8'h00;
  logic [15:0] pcIn     = 16'hfff0;  // near the top so targets wrap
  logic [7:0]  memData  = 8'h00;
  logic        irqLine  = 1'b0;
  logic [3:0]  regAddr  = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        busy, done, taken, illegal, memWe;
  logic [15:0] nextPc;
  logic [7:0]  memWdata, regRdata, rd;
  int          n_mismatch  = 0;
  int          checks_done = 0;

  cod_decode_timing cod_decode_timing_i (.clock, .sys_rst, .start, .opcode,
    .operand1, .operand2, .pcIn, .memData, .irqLine, .busy, .done, .taken,
    .illegal, .nextPc, .memWe, .memWdata, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata);

  always #2 clock = ~clock;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a);
    @(posedge clock);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask

  // n counts cycles from the taking edge to the done pulse
  task automatic runOp(input logic [7:0] op, o1, o2, m, input logic i,
                       output logic [15:0] n, output logic we);
    @(posedge clock);
    start    <= 1'b1;
    opcode   <= op;
    operand1 <= o1;
    operand2 <= o2;
    memData  <= m;
    irqLine  <= i;
    @(posedge clock);
    start <= 1'b0;
    #1;
    n = 16'h0001;
    while (done !== 1'b1 && n < 16'h0014)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    we = memWe;
    if (n >= 16'h0014)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // carry in is always set before a read-modify-write here
  function automatic logic [7:0] rmwRes(input logic [3:0] f,
                                        input logic [7:0] v);
    case (f)
      4'h0: return 8'h00 - v;
      4'h3: return ~v;
      4'h4: return v >> 1;
      4'h6: return {1'b1, v[7:1]};
      4'h7: return {v[7], v[7:1]};
      4'h8: return v << 1;
      4'h9: return {v[6:0], 1'b1};
      4'ha: return v - 8'h01;
      4'hc: return v + 8'h01;
      4'hf: return 8'h00;
      default: return v;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic relBranches;
    logic [4:0]  pats [4] = '{5'h00, 5'h1f, 5'h05, 5'h0a};
    logic [4:0]  f;
    logic [7:0]  off;
    logic [15:0] cyc;
    logic        tk, we, irq;
    for (int p = 0; p < 4; p++)
    begin
      f = pats[p];
      irq = f[0];
      off = irq ? 8'h7f : 8'h80;
      regWrite(cod_pkg::REG_CCR, {3'h0, f});
      for (int k = 0; k < 16; k++)
      begin
        case (k / 2)
          0: tk = 1'b1;
          1: tk = ~(f[cod_pkg::CCR_C] | f[cod_pkg::CCR_Z]);
          2: tk = ~f[cod_pkg::CCR_C];
          3: tk = ~f[cod_pkg::CCR_Z];
          4: tk = ~f[cod_pkg::CCR_H];
          5: tk = ~f[cod_pkg::CCR_N];
          6: tk = ~f[cod_pkg::CCR_I];
          default: tk = ~irq;
        endcase
        tk = tk ^ k[0];
        runOp(8'h20 + 8'(k), off, 8'h00, 8'h00, irq, cyc, we);
        check(cyc, 16'h0003);
        check(taken, tk);
        check(nextPc, 16'hfff2 + (tk ? {{8{off[7]}}, off} : 16'h0));
      end
    end
  endtask

  task automatic bitTests;
    logic [7:0]  m;
    logic [15:0] cyc;
    logic        b, tk, we;
    for (int k = 0; k < 32; k++)
    begin
      m = k[4] ? 8'ha5 : 8'h5a;
      b = m[k[3:1]];
      tk = b ^ k[0];
      runOp({4'h0, k[3:0]}, 8'h10, 8'h80, m, 1'b0, cyc, we);
      check(cyc, 16'h0005);
      check(taken, tk);
      check(nextPc, 16'hfff3 + (tk ? 16'hff80 : 16'h0));
      regRead(cod_pkg::REG_CCR);
      check(rd[cod_pkg::CCR_C], b);
    end
  endtask

  task automatic rmwOps;
    logic [3:0]  fns [11] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'ha, 4'hc, 4'hd, 4'hf};
    logic [3:0]  his [5] = '{4'h4, 4'h5, 4'h3, 4'h7, 4'h6};
    logic [7:0]  r;
    logic [15:0] cyc, ex;
    logic        we, tst, mem, cy;
    for (int h = 0; h < 5; h++)
      for (int f = 0; f < 11; f++)
      begin
        tst = fns[f] == 4'hd;
        // carry in is set and bit 0 of the operand clear: right shifts clear C
        cy = !(fns[f] inside {4'h4, 4'h6, 4'h7});
        mem = his[h] != 4'h4 && his[h] != 4'h5;
        r = rmwRes(fns[f], 8'h96);
        ex = !mem ? 16'h3 : (his[h] == 4'h6 ? 16'h6 : 16'h5);
        if (mem && tst)
          ex = ex - 16'h1;
        regWrite(cod_pkg::REG_ACC, 8'h96);
        regWrite(cod_pkg::REG_IDX, 8'h96);
        regWrite(cod_pkg::REG_CCR, 8'h01);
        runOp({his[h], fns[f]}, 8'h20, 8'h00, 8'h96, 1'b0, cyc, we);
        check(cyc, ex);
        check(we, mem & ~tst);
        check(nextPc, (his[h] == 4'h3 || his[h] == 4'h6) ? 16'hfff2
                                                        : 16'hfff1);
        if (mem && !tst)
          check(memWdata, r);
        if (!mem)
        begin
          regRead(his[h] == 4'h4 ? cod_pkg::REG_ACC : cod_pkg::REG_IDX);
          check(rd, r);
        end
        regRead(cod_pkg::REG_CCR);
        check({rd[cod_pkg::CCR_N], rd[cod_pkg::CCR_Z]},
              {r[7], r == 8'h00});
        check(rd[cod_pkg::CCR_C], cy);
      end
  endtask

  // an unlisted function nibble: flagged, one byte, two cycles
  task automatic illegalOp;
    logic [15:0] cyc;
    logic        we;
    runOp(8'h41, 8'h00, 8'h00, 8'h00, 1'b0, cyc, we);
    check(cyc, 16'h0002);
    check({illegal, taken, we}, 16'h4);
    regRead(cod_pkg::REG_STAT);
    check(rd, 8'h04);
    regRead(cod_pkg::REG_PCL);
    check(rd, 8'hf1);
    regRead(cod_pkg::REG_PCH);
    check(rd, 8'hff);
  endtask

  task automatic mulCtrl;
    logic [15:0] cyc;
    logic        we;
    regWrite(cod_pkg::REG_ACC, 8'hff);
    regWrite(cod_pkg::REG_IDX, 8'hfe);
    regWrite(cod_pkg::REG_CCR, 8'h1f);
    runOp(cod_pkg::OP_MUL, 8'h00, 8'h00, 8'h00, 1'b0, cyc, we);
    check(cyc, 16'h000b);
    regRead(cod_pkg::REG_IDX);
    check(rd, 8'hfd);
    regRead(cod_pkg::REG_ACC);
    check(rd, 8'h02);
    regRead(cod_pkg::REG_CCR);
    check(rd, 8'h0e);
    // each flag op starts from the opposite value of the bit it moves
    for (int k = 0; k < 4; k++)
    begin
      regWrite(cod_pkg::REG_CCR, k[0] ? 8'h00 : 8'h09);
      runOp(8'h98 + 8'(k), 8'h00, 8'h00, 8'h00, 1'b0, cyc, we);
      check(cyc, 16'h0002);
      check(nextPc, 16'hfff1);
      regRead(cod_pkg::REG_CCR);
      check(rd, (k[0] ^ k[1]) ? 8'h01 : 8'h08);
    end
  endtask

  task automatic resetValues;
    check({busy, done, memWe}, 16'h0);
    regRead(cod_pkg::REG_ACC);
    check(rd, cod_pkg::ACC_RST);
    regRead(cod_pkg::REG_CCR);
    check(rd, {3'h0, cod_pkg::CCR_RST});
    regRead(4'hf);
    check(rd, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    resetValues();
    relBranches();
    bitTests();
    rmwOps();
    mulCtrl();
    illegalOp();
    finish_test();
  end
endmodule
